// ==== design/link_param_pkg.sv ====
// Offsets, field layouts, reset values and helpers of the link parameter bank.
// Assumes an 8-bit port with a 12-bit byte address and one clock.
package link_param_pkg;

  // ==========================================================================
  // Register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] SCR_LANE_OFFSET  = 12'h289;
  localparam logic [11:0] OCTETS_OFFSET    = 12'h28A;
  localparam logic [11:0] FRAMES_OFFSET    = 12'h28B;
  localparam logic [11:0] CONVERTER_OFFSET = 12'h28C;
  localparam logic [11:0] CS_RES_OFFSET    = 12'h28D;
  localparam logic [11:0] SUB_NP_OFFSET    = 12'h28E;
  localparam logic [11:0] VER_S_OFFSET     = 12'h28F;
  localparam logic [11:0] HD_OFFSET        = 12'h290;

  // ==========================================================================
  // Field positions
  localparam int SCRAMBLE_BIT  = 7;
  localparam int LANE_MSB      = 4;
  localparam int CS_MSB        = 7;
  localparam int CS_LSB        = 6;
  localparam int RES_MSB       = 4;
  localparam int SUBCLASS_MSB  = 7;
  localparam int SUBCLASS_LSB  = 5;
  localparam int NP_MSB        = 4;
  localparam int VERSION_MSB   = 7;
  localparam int VERSION_LSB   = 5;
  localparam int SPF_MSB       = 4;
  localparam int HD_BIT        = 7;

  // ==========================================================================
  // Writable-bit masks; bits outside a mask are reserved and stay zero.
  localparam logic [7:0] SCR_LANE_MASK = 8'h9F;
  localparam logic [7:0] FULL_MASK     = 8'hFF;
  localparam logic [7:0] CS_RES_MASK   = 8'hDF;
  localparam logic [7:0] HD_MASK       = 8'h80;

  // ==========================================================================
  // Reset values and legal limits
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [4:0] LANE_CODE_MAX = 5'h03;
  localparam logic [2:0] VERSION_B     = 3'h1;

  // ==========================================================================
  // Alignment modes selected by the subclass field
  typedef enum logic [1:0] {
    MODE_ARBITRARY,
    MODE_SYSREF,
    MODE_SYNC,
    MODE_UNDEFINED
  } subclass_mode_t;

  // Keeps only the writable bits of a write, so reserved bits never store.
  function automatic logic [7:0] masked_write(input logic [7:0] data,
                                              input logic [7:0] mask);
    masked_write = data & mask;
  endfunction : masked_write

  // A zero count would give a zero-length period, so it acts as one.
  function automatic logic [7:0] at_least_one(input logic [7:0] count);
    at_least_one = (count == 8'h00) ? 8'h01 : count;
  endfunction : at_least_one

endpackage : link_param_pkg

// ==== design/link_param_check.sv ====
// Derives decoded link figures and legality flags from the raw parameter fields.
// Assumes the fields come from the register bank in the same clock domain.
`timescale 1ns/100ps
module link_param_check (
  input  wire logic                           sys_clk,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  input  wire logic [4:0]                     lane_code,
  input  wire logic [7:0]                     converter_code,
  input  wire logic [2:0]                     subclass_code,
  input  wire logic [2:0]                     version_code,
  output logic      [5:0]                     lanes_per_link,
  output logic      [8:0]                     converters_per_link,
  output logic                                lane_count_valid,
  output logic                                converter_count_valid,
  output logic                                version_valid,
  output link_param_pkg::subclass_mode_t      subclass_mode
);
  import link_param_pkg::*;

  typedef struct packed {
    logic [5:0]     lanes;
    logic [8:0]     converters;
    logic           lane_ok;
    logic           conv_ok;
    logic           ver_ok;
    subclass_mode_t mode;
  } check_state_t;

  check_state_t state;
  check_state_t next_state;

  // ==========================================================================
  // Decode
  // Registered so the link layer sees settled figures one cycle after a write.
  always_comb begin
    next_state            = state;
    next_state.lanes      = {1'b0, lane_code} + 6'h01;                        // [R2]
    next_state.lane_ok    = (lane_code <= LANE_CODE_MAX);                      // [R2]
    next_state.converters = {1'b0, converter_code} + 9'h001;                  // [R5]
    case (converter_code)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0B, 8'h0F: begin
        next_state.conv_ok = 1'b1;                                            // [R6]
      end
      default: begin
        next_state.conv_ok = 1'b0;
      end
    endcase
    case (subclass_code)
      3'h0: next_state.mode = MODE_ARBITRARY;                                 // [R9]
      3'h1: next_state.mode = MODE_SYSREF;                                    // [R9]
      3'h2: next_state.mode = MODE_SYNC;                                      // [R9]
      default: next_state.mode = MODE_UNDEFINED;
    endcase
    next_state.ver_ok = (version_code == VERSION_B);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign lanes_per_link        = state.lanes;
  assign converters_per_link   = state.converters;
  assign lane_count_valid      = state.lane_ok;
  assign converter_count_valid = state.conv_ok;
  assign version_valid         = state.ver_ok;
  assign subclass_mode         = state.mode;

endmodule : link_param_check

// ==== design/multiframe_timer.sv ====
// Local frame and multiframe timer, one octet per enabled clock.
// Assumes the counts are stable while running; a change needs a restart.
`timescale 1ns/100ps
module multiframe_timer (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       restart,
  input  wire logic [7:0] octets_per_frame,
  input  wire logic [7:0] frames_per_multiframe,
  output logic            frame_boundary,
  output logic            multiframe_boundary
);
  import link_param_pkg::*;

  typedef struct packed {
    logic [7:0] octet_cnt;
    logic [7:0] frame_cnt;
    logic       frame_end;
    logic       mframe_end;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;
  logic [7:0]   octet_last;
  logic [7:0]   frame_last;

  // Zero counts act as one so the timer never stalls on an unprogrammed bank.
  assign octet_last = at_least_one(octets_per_frame) - 8'h01;                  // [R3]
  assign frame_last = at_least_one(frames_per_multiframe) - 8'h01;             // [R4]

  // ==========================================================================
  // Counting
  always_comb begin
    next_state            = state;
    next_state.frame_end  = 1'b0;
    next_state.mframe_end = 1'b0;
    if (restart) begin
      next_state.octet_cnt = 8'h00;
      next_state.frame_cnt = 8'h00;
    end else if (state.octet_cnt >= octet_last) begin
      next_state.octet_cnt = 8'h00;
      next_state.frame_end = 1'b1;                                            // [R3]
      if (state.frame_cnt >= frame_last) begin
        next_state.frame_cnt  = 8'h00;
        next_state.mframe_end = 1'b1;                                         // [R4]
      end else begin
        next_state.frame_cnt = state.frame_cnt + 8'h01;
      end
    end else begin
      next_state.octet_cnt = state.octet_cnt + 8'h01;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign frame_boundary      = state.frame_end;
  assign multiframe_boundary = state.mframe_end;

endmodule : multiframe_timer

// ==== design/serial_link_param_regs.sv ====
// Link parameter register bank with decoded figures and a multiframe timer.
// Assumes a single-cycle register port master on sys_clk.
//
// Functional notes
// [R1] Scrambling of lane data is on when the scramble bit is one; reset clears it.
// [R2] Lane field holds lanes minus one; codes above three are flagged unsupported.
// [R3] Eight-bit octets-per-frame field, read/write, paces the frame timer.
// [R4] Eight-bit frames-per-multiframe field, read/write, sets the multiframe period.
// [R5] Converter field holds virtual converters minus one, zero to fifteen meaningful.
// [R6] Only converter codes 0,1,2,3,5,7,11,15 are legal; others flagged invalid.
// [R7] Two control-bit count bits sit in the top of their register, read/write.
// [R8] Five-bit total-bits-per-sample field, read/write.
// [R9] Subclass code 2 aligns to sync request, 1 to system reference, 0 arbitrary.
// [R10] Five-bit samples-per-converter-per-frame field in low bits, read/write.
// [R11] High-density bit set selects high-density lane packing; clear turns it off.
// [R12] Reserved bits read zero and ignore writes; every field resets to zero.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module serial_link_param_regs (
  input  wire logic                            sys_clk,
  input  wire logic                            reset_n,
  input  wire logic                            clk_en,
  input  wire logic [link_param_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [link_param_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                            reg_write,
  input  wire logic                            reg_read,
  output logic      [link_param_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                            framing_enable,
  output logic                                 scramble_enable,
  output logic      [4:0]                      lane_count_code,
  output logic      [7:0]                      octets_per_frame,
  output logic      [7:0]                      frames_per_multiframe,
  output logic      [7:0]                      converter_count_code,
  output logic      [1:0]                      control_bits,
  output logic      [4:0]                      resolution,
  output logic      [2:0]                      subclass_select,
  output logic      [4:0]                      total_sample_bits,
  output logic      [2:0]                      link_version_code,
  output logic      [4:0]                      samples_per_frame,
  output logic                                 high_density_enable,
  output logic      [5:0]                      lanes_per_link,
  output logic      [8:0]                      converters_per_link,
  output logic                                 lane_count_valid,
  output logic                                 converter_count_valid,
  output logic                                 version_valid,
  output link_param_pkg::subclass_mode_t       subclass_mode,
  output logic                                 frame_boundary,
  output logic                                 multiframe_boundary
);
  import link_param_pkg::*;

  // ==========================================================================
  // State
  // Each register keeps its whole byte; reserved bits are held at zero by
  // masking on write, so the read path needs no further masking.
  typedef struct packed {
    logic [7:0] scr_lane;
    logic [7:0] octets;
    logic [7:0] frames;
    logic [7:0] converter;
    logic [7:0] cs_res;
    logic [7:0] sub_np;
    logic [7:0] ver_s;
    logic [7:0] hd;
    logic [7:0] rdata;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;
  logic        timer_restart;

  // ==========================================================================
  // Register writes and read data
  // Read data is a one-cycle word; it returns to zero after its cycle, and an
  // unmapped address reads zero and ignores writes.
  always_comb begin
    next_state       = state;
    next_state.rdata = 8'h00;
    if (reg_write) begin
      case (reg_addr)
        SCR_LANE_OFFSET: begin
          next_state.scr_lane = masked_write(reg_wdata, SCR_LANE_MASK);      // [R12]
        end
        OCTETS_OFFSET: begin
          next_state.octets = masked_write(reg_wdata, FULL_MASK);            // [R3]
        end
        FRAMES_OFFSET: begin
          next_state.frames = masked_write(reg_wdata, FULL_MASK);            // [R4]
        end
        CONVERTER_OFFSET: begin
          next_state.converter = masked_write(reg_wdata, FULL_MASK);         // [R5]
        end
        CS_RES_OFFSET: begin
          next_state.cs_res = masked_write(reg_wdata, CS_RES_MASK);          // [R12]
        end
        SUB_NP_OFFSET: begin
          next_state.sub_np = masked_write(reg_wdata, FULL_MASK);            // [R8]
        end
        VER_S_OFFSET: begin
          next_state.ver_s = masked_write(reg_wdata, FULL_MASK);             // [R10]
        end
        HD_OFFSET: begin
          next_state.hd = masked_write(reg_wdata, HD_MASK);                  // [R12]
        end
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        SCR_LANE_OFFSET:  next_state.rdata = state.scr_lane;
        OCTETS_OFFSET:    next_state.rdata = state.octets;
        FRAMES_OFFSET:    next_state.rdata = state.frames;
        CONVERTER_OFFSET: next_state.rdata = state.converter;
        CS_RES_OFFSET:    next_state.rdata = state.cs_res;
        SUB_NP_OFFSET:    next_state.rdata = state.sub_np;
        VER_S_OFFSET:     next_state.rdata = state.ver_s;
        HD_OFFSET:        next_state.rdata = state.hd;
        default:          next_state.rdata = 8'h00;                          // [R12]
      endcase
    end
  end

  // ==========================================================================
  // State register
  // Synchronous reset clears every field; a low clock enable freezes the bank.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= {9{REG_RESET}};                                               // [R12]
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;

  // ==========================================================================
  // Field outputs to the link layer
  assign scramble_enable       = state.scr_lane[SCRAMBLE_BIT];                // [R1]
  assign lane_count_code       = state.scr_lane[LANE_MSB:0];                  // [R2]
  assign octets_per_frame      = state.octets;                                // [R3]
  assign frames_per_multiframe = state.frames;                                // [R4]
  assign converter_count_code  = state.converter;                             // [R5]
  assign control_bits          = state.cs_res[CS_MSB:CS_LSB];                 // [R7]
  assign resolution            = state.cs_res[RES_MSB:0];
  assign subclass_select       = state.sub_np[SUBCLASS_MSB:SUBCLASS_LSB];     // [R9]
  assign total_sample_bits     = state.sub_np[NP_MSB:0];                      // [R8]
  assign link_version_code     = state.ver_s[VERSION_MSB:VERSION_LSB];
  assign samples_per_frame     = state.ver_s[SPF_MSB:0];                      // [R10]
  assign high_density_enable   = state.hd[HD_BIT];                            // [R11]

  // ==========================================================================
  // Decoded figures and legality flags
  link_param_check u_check (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .clk_en                (clk_en),
    .lane_code             (state.scr_lane[LANE_MSB:0]),
    .converter_code        (state.converter),
    .subclass_code         (state.sub_np[SUBCLASS_MSB:SUBCLASS_LSB]),
    .version_code          (state.ver_s[VERSION_MSB:VERSION_LSB]),
    .lanes_per_link        (lanes_per_link),
    .converters_per_link   (converters_per_link),
    .lane_count_valid      (lane_count_valid),
    .converter_count_valid (converter_count_valid),
    .version_valid         (version_valid),
    .subclass_mode         (subclass_mode)
  );

  // ==========================================================================
  // Local multiframe timer
  // Restarting on a write to either count keeps a half-old period from being
  // emitted after software changes the framing.
  assign timer_restart = !framing_enable
                       || (reg_write && (reg_addr == OCTETS_OFFSET))
                       || (reg_write && (reg_addr == FRAMES_OFFSET));        // [R4]

  multiframe_timer u_timer (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .clk_en                (clk_en),
    .restart               (timer_restart),
    .octets_per_frame      (state.octets),
    .frames_per_multiframe (state.frames),
    .frame_boundary        (frame_boundary),
    .multiframe_boundary   (multiframe_boundary)
  );

endmodule : serial_link_param_regs

// ==== verif/link_param_properties.sv ====
// Concurrent checks on the ports of the serial link parameter bank.
// Assumes one clock domain and a bind onto every bank instance.
`timescale 1ns/100ps
module link_param_properties
  import link_param_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic                 clk_en,
  input wire logic [11:0]          reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_write,
  input wire logic                 reg_read,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 framing_enable,
  input wire logic                 scramble_enable,
  input wire logic [4:0]           lane_count_code,
  input wire logic [7:0]           octets_per_frame,
  input wire logic [7:0]           converter_count_code,
  input wire logic [2:0]           subclass_select,
  input wire logic                 high_density_enable,
  input wire logic [5:0]           lanes_per_link,
  input wire logic [8:0]           converters_per_link,
  input wire logic                 lane_count_valid,
  input wire logic                 converter_count_valid,
  input wire subclass_mode_t       subclass_mode,
  input wire logic                 frame_boundary,
  input wire logic                 multiframe_boundary
);
  // ==========================================================================
  // Taken writes, decoded once so the properties stay short.
  logic wr_scr;
  logic wr_oct;
  logic wr_hd;
  assign wr_scr = clk_en && reg_write && reg_addr == SCR_LANE_OFFSET;
  assign wr_oct = clk_en && reg_write && reg_addr == OCTETS_OFFSET;
  assign wr_hd  = clk_en && reg_write && reg_addr == HD_OFFSET;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Field storage, decoding and timer relations.
  a_scramble_store: assert property (wr_scr |=> scramble_enable == $past(reg_wdata[7]))
    else $error("scramble bit did not follow the write");
  a_lane_decode: assert property (clk_en |=> lanes_per_link == {1'b0, $past(lane_count_code)}
    + 6'h01 && lane_count_valid == ($past(lane_count_code) <= LANE_CODE_MAX))
    else $error("lane count decode wrong");
  a_octets_store: assert property (wr_oct |=> octets_per_frame == $past(reg_wdata))
    else $error("octet count did not store");
  a_octets_hold: assert property (!wr_oct |=> $stable(octets_per_frame))
    else $error("octet count changed without a write");
  a_conv_decode: assert property (clk_en |=>
    converters_per_link == {1'b0, $past(converter_count_code)} + 9'h001)
    else $error("converter count decode wrong");
  a_conv_legal: assert property (clk_en |=> converter_count_valid == ($past(converter_count_code)
    inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0B, 8'h0F}))
    else $error("converter legality flag wrong");
  a_subclass_mode: assert property (clk_en |=> subclass_mode ==
    ($past(subclass_select) == 3'h2 ? MODE_SYNC : $past(subclass_select) == 3'h1 ? MODE_SYSREF :
    $past(subclass_select) == 3'h0 ? MODE_ARBITRARY : MODE_UNDEFINED))
    else $error("alignment mode wrong");
  a_density_store: assert property (wr_hd |=> high_density_enable == $past(reg_wdata[7]))
    else $error("density bit did not follow the write");
  a_rdata_idle: assert property (clk_en && !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_multi_pair: assert property (multiframe_boundary |-> frame_boundary)
    else $error("multiframe pulse without frame pulse");
  a_frame_quiet: assert property (clk_en && !framing_enable |=> !frame_boundary)
    else $error("frame pulse while framing is off");
endmodule : link_param_properties

bind serial_link_param_regs link_param_properties u_props (.*);

// ==== verif/config_host.sv ====
// Model of the configuring software: single-cycle register writes and reads.
// Assumes a slave that never stalls and answers a read in the following cycle.
`timescale 1ns/100ps
module config_host
  import link_param_pkg::*;
(
  input  wire logic        sys_clk,
  output logic      [11:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  input  wire logic [7:0]  reg_rdata
);
  // Set only by scenarios that program unsupported codes on purpose.
  logic allow_bad = 1'b0;

  // ==========================================================================
  // Idle bus at time zero.
  initial begin
    reg_addr  = 12'h000;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  // Legal software never programs unsupported codes.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (!allow_bad && a == SCR_LANE_OFFSET && d[4:0] > LANE_CODE_MAX) v[4:0] = LANE_CODE_MAX;
    if (!allow_bad && a == CONVERTER_OFFSET && !(d inside {0, 1, 2, 3, 5, 7, 11, 15})) v = 8'h00;
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_wdata <= ~v;
  endtask : wr

  // Data is taken mid-cycle after the strobe, where it is settled.
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
endmodule : config_host

// ==== verif/tb.sv ====
// Self-checking bench for the serial link parameter bank.
// Assumes the configuring-software model drives the register port.
`timescale 1ns/100ps
module tb;
  import link_param_pkg::*;
  logic sys_clk, reset_n, clk_en, framing_enable, reg_write, reg_read;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, octets_per_frame, frames_per_multiframe, rd_val;
  logic [7:0] converter_count_code;
  logic scramble_enable, high_density_enable, lane_count_valid, converter_count_valid;
  logic version_valid, frame_boundary, multiframe_boundary;
  logic [4:0] lane_count_code, resolution, total_sample_bits, samples_per_frame;
  logic [2:0] subclass_select, link_version_code;
  logic [1:0] control_bits;
  logic [5:0] lanes_per_link;
  logic [8:0] converters_per_link;
  subclass_mode_t subclass_mode, exp_mode;
  int fail_count, checks_done, cycles, frames, multis;
  logic [11:0] offs [8] = '{SCR_LANE_OFFSET, OCTETS_OFFSET, FRAMES_OFFSET, CONVERTER_OFFSET,
                            CS_RES_OFFSET, SUB_NP_OFFSET, VER_S_OFFSET, HD_OFFSET};
  logic [7:0] masks [8] = '{SCR_LANE_MASK, FULL_MASK, FULL_MASK, FULL_MASK, CS_RES_MASK,
                            FULL_MASK, FULL_MASK, HD_MASK};

  config_host host (.*);
  serial_link_param_regs DUT (.*);

  // ==========================================================================
  // Clock and a cycle ceiling that cuts a hang short.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end

  // Four-state compare, so an unknown never passes.
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Counts timer pulses over eight settled cycles.
  task automatic count_pulses;
    frames = 0;
    multis = 0;
    repeat (8) begin
      @(negedge sys_clk);
      frames += frame_boundary;
      multis += multiframe_boundary;
    end
  endtask : count_pulses

  task automatic results;
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ==========================================================================
  // Main sequence.
  initial begin
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    framing_enable = 1'b1;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      host.rd(offs[i], rd_val);
      check("reset value", rd_val, 8'h00);
    end
    // All ones shows which bits are writable and which are reserved.
    host.allow_bad = 1'b1;
    for (int i = 0; i < 8; i++) begin
      host.wr(offs[i], 8'hFF);
      host.rd(offs[i], rd_val);
      check("writable bits", rd_val, masks[i]);
    end
    check("scramble on", scramble_enable, 1'b1);
    check("control bits", control_bits, 2'h3);
    check("total bits", total_sample_bits, 5'h1F);
    check("samples", samples_per_frame, 5'h1F);
    check("density on", high_density_enable, 1'b1);
    check("lane flag", lane_count_valid, 1'b0);
    for (int i = 0; i < 8; i++) host.wr(offs[i], 8'h00);
    @(negedge sys_clk);
    check("scramble off", scramble_enable, 1'b0);
    check("density off", high_density_enable, 1'b0);
    // Lane and converter codes, including the first unsupported lane code.
    for (int c = 0; c < 5; c++) begin
      host.wr(SCR_LANE_OFFSET, 8'(c));
      repeat (2) @(negedge sys_clk);
      check("lanes", lanes_per_link, 9'(c + 1));
      check("lane flag", lane_count_valid, c <= 3);
    end
    for (int c = 0; c < 16; c++) begin
      host.wr(CONVERTER_OFFSET, 8'(c));
      repeat (2) @(negedge sys_clk);
      check("converters", converters_per_link, 9'(c + 1));
      check("converter flag", converter_count_valid, c inside {0, 1, 2, 3, 5, 7, 11, 15});
    end
    for (int c = 0; c < 8; c++) begin
      host.wr(SUB_NP_OFFSET, {3'(c), 5'h00});
      repeat (2) @(negedge sys_clk);
      exp_mode = c == 2 ? MODE_SYNC : c == 1 ? MODE_SYSREF : c == 0 ? MODE_ARBITRARY : MODE_UNDEFINED;
      check("alignment mode", subclass_mode, exp_mode);
    end
    // Unmapped neighbours must neither store nor disturb the bank.
    host.wr(12'h288, 8'hFF);
    host.wr(12'h291, 8'hFF);
    host.rd(12'h291, rd_val);
    check("unmapped read", rd_val, 8'h00);
    host.rd(SCR_LANE_OFFSET, rd_val);
    check("neighbour kept", rd_val, 8'h04);
    // Two octets per frame and two frames per multiframe.
    host.wr(OCTETS_OFFSET, 8'h02);
    host.wr(FRAMES_OFFSET, 8'h02);
    repeat (3) @(negedge sys_clk);
    count_pulses();
    check("frame pulses", 9'(frames), 9'h004);
    check("multiframe pulses", 9'(multis), 9'h002);
    @(posedge sys_clk);
    framing_enable <= 1'b0;
    count_pulses();
    check("frames held", 9'(frames), 9'h000);
    // A write while the clock enable is low is ignored.
    clk_en <= 1'b0;
    host.wr(OCTETS_OFFSET, 8'h07);
    clk_en <= 1'b1;
    host.rd(OCTETS_OFFSET, rd_val);
    check("gated write", rd_val, 8'h02);
    // A second reset mid-run clears every field.
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check("reset octets", octets_per_frame, 8'h00);
    check("reset lanes code", lane_count_code, 5'h00);
    results();
  end
endmodule : tb
